//--- design/enhanced_serial_port.sv
// serial port: shift mode, three asynchronous modes, framing error flag
`default_nettype none
module enhanced_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] serial_data_reg,
  input wire logic serial_control_reg_wr,
  input wire serial_port_pkg::serial_control_t serial_control_reg_wdata,
  output serial_port_pkg::serial_control_t serial_control_reg_rd,
  input wire logic baud_double,
  input wire logic error_flag_select,
  input wire logic timer_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);
  import serial_port_pkg::*;
  // ************************************************
  // control state and mode decode
  // ************************************************
  serial_control_t ctl_ff;
  logic fe_ff;
  logic [1:0] mode;
  logic shift_mode;
  logic wide_frame;
  logic ti_set;
  logic ri_set;
  logic rb8_set;
  logic rb8_val;
  logic fe_set;
  logic [7:0] rx_data;
  assign mode = {ctl_ff.mode_hi_or_error, ctl_ff.mode_select_lo};
  assign shift_mode = (mode == MODE_SHIFT);
  assign wide_frame = (mode == MODE_FIXED11) || (mode == MODE_TIMER11);
  // ************************************************
  // baud tick at sixteen times the bit rate
  // ************************************************
  logic half_ff;
  logic tick_src;
  logic tick16;
  assign tick_src = (mode == MODE_FIXED11) ? 1'b1 : timer_ovf;
  assign tick16 = tick_src && (baud_double || half_ff);
  // halve the tick source when baud doubling is off
  always_ff @(posedge clk)
  begin
    if (rst)
      half_ff <= 1'b0;
    else if (tick_src)
      half_ff <= !half_ff;
  end
  // ************************************************
  // shift mode engine
  // ************************************************
  shift_state_t m0_ff;
  logic [3:0] ph_ff;
  logic [3:0] m0_cnt_ff;
  logic [7:0] m0_sh_ff;
  logic sclk_ff;
  logic [3:0] period;
  logic [3:0] lead;
  logic [3:0] rise;
  logic m0_end;
  logic m0_rise;
  logic m0_tx_done;
  logic m0_rx_done;
  assign period = ctl_ff.multiproc_enable ? M0_PERIOD_FAST : M0_PERIOD_SLOW;
  assign lead = ctl_ff.multiproc_enable ? M0_LEAD_FAST : M0_LEAD_SLOW;
  // last low phase: the clock rises at the edge that ends it
  assign rise = lead + (ctl_ff.multiproc_enable ? M0_LOW_FAST : M0_LOW_SLOW)
    - 4'h1;
  assign m0_end = (ph_ff == period - 4'h1);
  assign m0_rise = (ph_ff == rise);
  assign m0_tx_done = (m0_ff == M0_TX) && m0_end
    && (m0_cnt_ff == LAST_DATA_BIT);
  assign m0_rx_done = (m0_ff == M0_RX) && m0_rise
    && (m0_cnt_ff == LAST_DATA_BIT);
  // bit sequencing, one bit per shift clock period
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      m0_ff <= M0_IDLE;
      ph_ff <= 4'h0;
      m0_cnt_ff <= 4'h0;
      m0_sh_ff <= DATA_RESET;
    end
    else
    begin
      unique case (m0_ff)
        M0_IDLE:
        begin
          ph_ff <= 4'h0;
          m0_cnt_ff <= 4'h0;
          if (shift_mode && data_wr)
          begin
            m0_sh_ff <= data_wdata;
            m0_ff <= M0_TX;
          end
          else if (shift_mode && ctl_ff.receive_enable
                   && !ctl_ff.receive_done_flag)
            m0_ff <= M0_RX;
        end
        M0_TX:
        begin
          ph_ff <= m0_end ? 4'h0 : ph_ff + 4'h1;
          if (m0_end)
          begin
            m0_sh_ff <= {1'b0, m0_sh_ff[7:1]};
            m0_cnt_ff <= m0_cnt_ff + 4'h1;
            if (m0_tx_done)
              m0_ff <= M0_IDLE;
          end
        end
        M0_RX:
        begin
          ph_ff <= m0_end ? 4'h0 : ph_ff + 4'h1;
          if (m0_rise)
          begin
            m0_sh_ff <= {rxd_in, m0_sh_ff[7:1]};
            m0_cnt_ff <= m0_cnt_ff + 4'h1;
          end
          if (m0_rx_done)
            m0_ff <= M0_IDLE;
        end
        default: m0_ff <= M0_IDLE;
      endcase
    end
  end
  // shift clock: falls after the data lead, rises after the low time
  always_ff @(posedge clk)
  begin
    if (rst || m0_ff == M0_IDLE)
      sclk_ff <= 1'b1;
    else if (ph_ff == lead - 4'h1)
      sclk_ff <= 1'b0;
    else if (m0_rise)
      sclk_ff <= 1'b1;
  end
  // ************************************************
  // asynchronous transmitter
  // ************************************************
  tx_state_t tx_ff;
  logic [3:0] tx_div_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_left_ff;
  logic line_ff;
  logic tx_roll;
  logic tx_done;
  assign tx_roll = tick16 && (tx_div_ff == OVS_LAST);
  assign tx_done = (tx_ff == TX_SEND) && tx_roll && (tx_left_ff == 4'h1);
  // free running divide-by-16 that frames the transmit bits
  always_ff @(posedge clk)
  begin
    if (rst)
      tx_div_ff <= 4'h0;
    else if (tick16)
      tx_div_ff <= tx_div_ff + 4'h1;
  end
  // frame load on write, one bit out per rollover
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_ff <= TX_IDLE;
      tx_sh_ff <= '1;
      tx_left_ff <= 4'h0;
      line_ff <= 1'b1;
    end
    else if (!shift_mode && data_wr)
    begin
      tx_ff <= TX_SEND;
      tx_left_ff <= wide_frame ? FRAME11_BITS : FRAME10_BITS;
      tx_sh_ff <= {1'b1, wide_frame ? ctl_ff.transmit_ninth_bit : 1'b1,
        data_wdata, 1'b0};
    end
    else if (tx_ff == TX_SEND && tx_roll)
    begin
      line_ff <= tx_sh_ff[0];
      tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
      tx_left_ff <= tx_left_ff - 4'h1;
      if (tx_done)
        tx_ff <= TX_IDLE;
    end
  end
  // ************************************************
  // asynchronous receiver
  // ************************************************
  rx_state_t rx_ff;
  logic [3:0] rx_div_ff;
  logic [3:0] rx_idx_ff;
  logic rx_prev_ff;
  logic [1:0] smp_ff;
  logic [7:0] rx_sh_ff;
  logic ninth_ff;
  logic vote;
  logic vote_now;
  logic rx_last;
  logic accept;
  assign vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rxd_in)
    | (smp_ff[1] & rxd_in);
  assign vote_now = (rx_ff == RX_FRAME) && tick16 && (rx_div_ff == SAMPLE_C);
  assign rx_last = vote_now
    && (rx_idx_ff == (wide_frame ? FRAME11_BITS : FRAME10_BITS) - 4'h1);
  assign rb8_val = wide_frame ? ninth_ff : vote;
  assign accept = rx_last && !ctl_ff.receive_done_flag
    && (!ctl_ff.multiproc_enable || rb8_val);
  // edge hunt, bit slicing and voting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_ff <= RX_HUNT;
      rx_div_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_prev_ff <= 1'b1;
      smp_ff <= 2'h0;
      rx_sh_ff <= DATA_RESET;
      ninth_ff <= 1'b0;
    end
    else if (tick16)
    begin
      rx_prev_ff <= rxd_in;
      unique case (rx_ff)
        RX_HUNT:
        begin
          rx_div_ff <= 4'h0;
          rx_idx_ff <= 4'h0;
          if (!shift_mode && ctl_ff.receive_enable && rx_prev_ff && !rxd_in)
            rx_ff <= RX_FRAME;
        end
        RX_FRAME:
        begin
          rx_div_ff <= rx_div_ff + 4'h1;
          if (rx_div_ff == SAMPLE_A)
            smp_ff[0] <= rxd_in;
          if (rx_div_ff == SAMPLE_B)
            smp_ff[1] <= rxd_in;
          if (vote_now)
          begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == 4'h0 && vote)
              rx_ff <= RX_HUNT;
            else if (rx_last)
              rx_ff <= RX_HUNT;
            else if (wide_frame && rx_idx_ff == NINTH_INDEX)
              ninth_ff <= vote;
            else if (rx_idx_ff != 4'h0)
              rx_sh_ff <= {vote, rx_sh_ff[7:1]};
          end
        end
        default: rx_ff <= RX_HUNT;
      endcase
    end
  end
  // ************************************************
  // flags, buffer and pins
  // ************************************************
  assign ti_set = m0_tx_done || tx_done;
  assign ri_set = m0_rx_done || accept;
  assign rb8_set = accept;
  assign fe_set = rx_last && !vote;
  assign rx_data = m0_rx_done ? {rxd_in, m0_sh_ff[7:1]} : rx_sh_ff;
  // control bits: software writes, hardware sets win over clears
  always_ff @(posedge clk)
  begin
    if (rst)
      ctl_ff <= CONTROL_RESET;
    else
    begin
      if (serial_control_reg_wr)
      begin
        ctl_ff <= serial_control_reg_wdata;
        if (error_flag_select)
          ctl_ff.mode_hi_or_error <= ctl_ff.mode_hi_or_error;
      end
      if (ti_set)
        ctl_ff.transmit_done_flag <= 1'b1;
      if (ri_set)
        ctl_ff.receive_done_flag <= 1'b1;
      if (rb8_set)
        ctl_ff.received_ninth_bit <= rb8_val;
    end
  end
  // framing error: set by hardware only, cleared by writing zero to bit 7 while error_flag_select is high
  always_ff @(posedge clk)
  begin
    if (rst)
      fe_ff <= 1'b0;
    else if (fe_set)
      fe_ff <= 1'b1;
    else if (serial_control_reg_wr && error_flag_select && !serial_control_reg_wdata.mode_hi_or_error)
      fe_ff <= 1'b0;
  end
  // receive buffer; writes go to the transmitter only
  always_ff @(posedge clk)
  begin
    if (rst)
      serial_data_reg <= DATA_RESET;
    else if (m0_rx_done || accept)
      serial_data_reg <= rx_data;
  end
  // registered pins and control readback
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      serial_control_reg_rd <= CONTROL_RESET;
    end
    else
    begin
      txd <= shift_mode ? sclk_ff : line_ff;
      rxd_out <= m0_sh_ff[0];
      rxd_oe <= (m0_ff == M0_TX);
      serial_control_reg_rd <= ctl_ff;
      serial_control_reg_rd.mode_hi_or_error <= error_flag_select ? fe_ff
        : ctl_ff.mode_hi_or_error;
    end
  end
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] roll_cnt_ff;
  // rollovers seen since the last asynchronous write
  always_ff @(posedge clk)
  begin
    if (rst || (!shift_mode && data_wr))
      roll_cnt_ff <= 4'h0;
    else if (tx_roll && tx_ff == TX_SEND)
      roll_cnt_ff <= roll_cnt_ff + 4'h1;
  end
  chk_write_keeps_buffer: assert property (
    data_wr && !ri_set |=> $stable(serial_data_reg))
    else $error("data write changed receive buffer");
  chk_fast_low_time: assert property (
    $fell(sclk_ff) && ctl_ff.multiproc_enable
    |-> !sclk_ff [*2] ##1 sclk_ff)
    else $error("fast shift clock low time wrong");
  chk_slow_low_time: assert property (
    $fell(sclk_ff) && !ctl_ff.multiproc_enable
    |-> !sclk_ff [*6] ##1 sclk_ff)
    else $error("slow shift clock low time wrong");
  chk_start_on_roll: assert property (
    $fell(line_ff) |-> $past(tx_roll))
    else $error("start bit not on rollover");
  chk_done_rollover: assert property (
    tx_done |-> roll_cnt_ff + 4'h1
    == (wide_frame ? FRAME11_BITS : FRAME10_BITS))
    else $error("transmit done at wrong rollover");
  chk_start_abort: assert property (
    vote_now && rx_idx_ff == 4'h0 && vote |=> rx_ff == RX_HUNT)
    else $error("bad start bit not abandoned");
  chk_fe_sticky: assert property (
    fe_ff && !(serial_control_reg_wr && error_flag_select) |=> fe_ff)
    else $error("framing error cleared by hardware");
  chk_full_buffer_held: assert property (
    ctl_ff.receive_done_flag && !serial_control_reg_wr |=> $stable(serial_data_reg))
    else $error("receive buffer overwritten while flag set");
  chk_stop_sets_fe: assert property (
    rx_last && !vote |=> fe_ff)
    else $error("missing stop bit not flagged");
  cov_shift_tx: cover property (m0_tx_done);
  cov_shift_rx: cover property (m0_rx_done);
  cov_async_rx: cover property (accept && wide_frame);
  cov_frame_err: cover property (fe_set);
endmodule : enhanced_serial_port
`default_nettype wire

//--- inc/serial_port_pkg.sv
// constants, control layout and state codes of the enhanced serial port
`default_nettype none
package serial_port_pkg;
  // ************************************************
  // mode codes of the two mode-select bits
  // ************************************************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC10 = 2'h1;
  localparam logic [1:0] MODE_FIXED11 = 2'h2;
  localparam logic [1:0] MODE_TIMER11 = 2'h3;
  // ************************************************
  // frame and oversampling figures
  // ************************************************
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] FRAME10_BITS = 4'ha;
  localparam logic [3:0] FRAME11_BITS = 4'hb;
  localparam logic [3:0] NINTH_INDEX = 4'h9;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  // ************************************************
  // shift mode timing in oscillator clocks
  // ************************************************
  localparam logic [3:0] M0_PERIOD_SLOW = 4'hc;
  localparam logic [3:0] M0_PERIOD_FAST = 4'h4;
  localparam logic [3:0] M0_LEAD_SLOW = 4'h3;
  localparam logic [3:0] M0_LEAD_FAST = 4'h1;
  localparam logic [3:0] M0_LOW_SLOW = 4'h6;
  localparam logic [3:0] M0_LOW_FAST = 4'h2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // serial control register layout, bit 7 first
  typedef struct packed {
    logic mode_hi_or_error;
    logic mode_select_lo;
    logic multiproc_enable;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } serial_control_t;
  localparam serial_control_t CONTROL_RESET = 8'h00;
  typedef enum logic [2:0] {M0_IDLE = 3'h1, M0_TX = 3'h2, M0_RX = 3'h4}
    shift_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_state_t;
  typedef enum logic [1:0] {RX_HUNT = 2'h1, RX_FRAME = 2'h2} rx_state_t;
endpackage : serial_port_pkg
`default_nettype wire

//--- test/remote_node.sv
// remote serial node: async frames and a mode 0 shift device
`default_nettype none
module remote_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_ff;
  logic on_ff;
  int idx;
  // ********
  // line drive
  // ********
  // line idles high like a pulled-up pin
  initial
  begin
    rxd_drv = 1'b1;
    on_ff = 1'b0;
  end
  // present the next bit at each shift clock fall
  always @(negedge txd)
    if (on_ff)
    begin
      rxd_drv <= sh_ff[idx[2:0]];
      idx++;
    end
  // arm or park the shift device
  task automatic load(input logic [7:0] b, input logic on);
    sh_ff = b;
    idx = 0;
    on_ff = on;
    rxd_drv <= 1'b1;
  endtask : load
  // drive a frame lsb first, bt clocks per bit
  task automatic send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++)
    begin
      rxd_drv <= f[i];
      repeat (bt) @(posedge clk);
    end
    rxd_drv <= 1'b1;
  endtask : send
  // wait for a start bit, then sample each bit mid-way
  task automatic catch(input int n, input int bt, output logic [10:0] f);
    f = '1;
    for (int c = 0; c < 4000 && txd; c++)
      @(posedge clk);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      repeat (bt) @(posedge clk);
    end
  endtask : catch
endmodule : remote_node
`default_nettype wire

//--- test/test_enhanced_serial_port.sv
// self-checking bench of the enhanced serial port
`default_nettype none
module test_enhanced_serial_port
  import serial_port_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic data_wr;
  logic [7:0] data_wdata;
  logic [7:0] serial_data_reg;
  logic serial_control_reg_wr;
  serial_control_t serial_control_reg_wdata;
  serial_control_t serial_control_reg_rd;
  logic baud_double;
  logic error_flag_select;
  logic timer_ovf = 1'b0;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe;
  logic txd;
  logic node_drv;
  int fails = 0;
  int checked = 0;
  // ********
  // clock, pin and instances
  // ********
  // 25 MHz oscillator
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // timer overflow every other clock
  always @(posedge clk)
    timer_ovf <= ~timer_ovf;
  // rxd pin level from both drivers
  assign rxd_in = rxd_oe ? rxd_out : node_drv;
  enhanced_serial_port i_enhanced_serial_port (
    .clk(clk),
    .rst(rst),
    .data_wr(data_wr),
    .data_wdata(data_wdata),
    .serial_data_reg(serial_data_reg),
    .serial_control_reg_wr(serial_control_reg_wr),
    .serial_control_reg_wdata(serial_control_reg_wdata),
    .serial_control_reg_rd(serial_control_reg_rd),
    .baud_double(baud_double),
    .error_flag_select(error_flag_select),
    .timer_ovf(timer_ovf),
    .rxd_in(rxd_in),
    .rxd_out(rxd_out),
    .rxd_oe(rxd_oe),
    .txd(txd)
  );
  remote_node i_remote_node (
    .clk(clk),
    .txd(txd),
    .rxd_drv(node_drv)
  );
  // ********
  // helpers
  // ********
  // compare and count
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write to data (d=1) or control (d=0)
  task automatic wr(input logic d, input logic [7:0] v);
    @(posedge clk);
    data_wr <= d;
    serial_control_reg_wr <= !d;
    data_wdata <= v;
    serial_control_reg_wdata <= v;
    @(posedge clk);
    data_wr <= 1'b0;
    serial_control_reg_wr <= 1'b0;
  endtask : wr
  // ********
  // scenarios
  // ********
  // shift mode send: order, period and low time at txd
  task automatic shift_tx(input logic sm2);
    logic [7:0] got;
    logic p;
    logic q;
    int k;
    int last;
    int fl;
    int dc;
    k = 0;
    last = 0;
    fl = 0;
    dc = -1;
    got = '0;
    wr(1'b0, {2'b00, sm2, 5'h00});
    wr(1'b1, 8'hc6);
    p = txd;
    q = rxd_out;
    for (int c = 0; c < 200 && k < 8; c++)
    begin
      @(posedge clk);
      #1;
      // data edge to clock fall distance
      if (rxd_out !== q)
        dc = c;
      if (!txd && p)
      begin
        fl = c;
        if (dc >= 0)
          chk(11'(c - dc), sm2 ? 11'h001 : 11'h003);
        dc = -1;
      end
      if (txd && !p)
      begin
        got[k[2:0]] = rxd_out;
        chk(11'(rxd_oe), 11'h001);
        chk(11'(c - fl), sm2 ? 11'h002 : 11'h006);
        if (k > 0)
          chk(11'(c - last), sm2 ? 11'h004 : 11'h00c);
        last = c;
        k++;
      end
      p = txd;
      q = rxd_out;
    end
    for (int c = 0; c < 40 && serial_control_reg_rd[1] !== 1'b1; c++)
      @(posedge clk);
    chk(11'(got), 11'h0c6);
    chk(11'(serial_control_reg_rd[1]), 11'h001);
    $display("shift_tx done");
  endtask : shift_tx
  // shift mode receive from the shift device
  task automatic shift_rx;
    i_remote_node.load(8'h93, 1'b1);
    wr(1'b0, 8'h10);
    for (int c = 0; c < 300 && serial_control_reg_rd[0] !== 1'b1; c++)
      @(posedge clk);
    chk(11'(serial_data_reg), 11'h093);
    chk(11'(rxd_oe), 11'h000);
    i_remote_node.load(8'h00, 1'b0);
    $display("shift_rx done");
  endtask : shift_rx
  // one frame out and one in for an async mode
  task automatic async_case(input logic [1:0] m, input logic bd);
    logic [10:0] f;
    logic [10:0] e;
    logic ten;
    int bt;
    ten = (m == MODE_ASYNC10);
    bt = (m == MODE_FIXED11) ? 16 : 32;
    if (!bd)
      bt = bt * 2;
    e = ten ? {2'b11, 8'ha5, 1'b0} : {1'b1, bd, 8'ha5, 1'b0};
    baud_double <= bd;
    wr(1'b0, {m, 2'b01, bd, 3'h0});
    wr(1'b1, 8'ha5);
    i_remote_node.catch(ten ? 10 : 11, bt, f);
    chk(f, e);
    chk(11'(serial_control_reg_rd[1]), 11'h001);
    e = ten ? {2'b11, 8'h3c, 1'b0} : {1'b1, !bd, 8'h3c, 1'b0};
    i_remote_node.send(e, ten ? 10 : 11, bt);
    repeat (2) @(posedge clk);
    f = {1'b0, serial_control_reg_rd[2], serial_control_reg_rd[0], serial_data_reg};
    chk(f, {1'b0, ten | !bd, 1'b1, 8'h3c});
    $display("async_case done");
  endtask : async_case
  // start glitch, framing error, full buffer, flag select
  task automatic error_case;
    baud_double <= 1'b1;
    // mode 01 must be written while bit 7 still reaches the mode bit
    wr(1'b0, 8'h50);
    error_flag_select <= 1'b1;
    i_remote_node.send(11'h000, 1, 6);
    repeat (64) @(posedge clk);
    chk(11'(serial_control_reg_rd[0]), 11'h000);
    i_remote_node.send({2'b00, 8'h81, 1'b0}, 10, 32);
    repeat (2) @(posedge clk);
    chk({1'b0, serial_control_reg_rd[7], serial_control_reg_rd[0], serial_data_reg}, 11'h381);
    i_remote_node.send({2'b11, 8'h7e, 1'b0}, 10, 32);
    repeat (2) @(posedge clk);
    chk({1'b0, serial_control_reg_rd[7], serial_control_reg_rd[0], serial_data_reg}, 11'h381);
    error_flag_select <= 1'b0;
    repeat (2) @(posedge clk);
    chk(11'(serial_control_reg_rd[7]), 11'h000);
    error_flag_select <= 1'b1;
    wr(1'b0, 8'h50);
    wr(1'b0, 8'hd0);
    repeat (2) @(posedge clk);
    chk(11'({serial_control_reg_rd[7], serial_control_reg_rd[6]}), 11'h001);
    $display("error_case done");
  endtask : error_case
  // multiprocessor gate on the received ninth bit
  task automatic mproc_case;
    logic [10:0] f;
    error_flag_select <= 1'b0;
    baud_double <= 1'b1;
    wr(1'b0, 8'hb0);
    i_remote_node.send({2'b10, 8'h11, 1'b0}, 11, 16);
    i_remote_node.send({2'b11, 8'h22, 1'b0}, 11, 16);
    repeat (2) @(posedge clk);
    f = {1'b0, serial_control_reg_rd[2], serial_control_reg_rd[0], serial_data_reg};
    chk(f, 11'h322);
    $display("mproc_case done");
  endtask : mproc_case
  // counts and verdict
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // reset, then the scenarios in turn
  initial
  begin
    rst <= 1'b1;
    data_wr <= 1'b0;
    data_wdata <= 8'h00;
    serial_control_reg_wr <= 1'b0;
    serial_control_reg_wdata <= 8'h00;
    baud_double <= 1'b0;
    error_flag_select <= 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    shift_tx(1'b1);
    shift_tx(1'b0);
    shift_rx();
    for (int i = 1; i < 4; i++)
    begin
      async_case(2'(i), 1'b1);
      async_case(2'(i), 1'b0);
    end
    error_case();
    mproc_case();
    summarize();
  end
endmodule : test_enhanced_serial_port
`default_nettype wire
